// File: logic/oag_pkg.sv
// package for the operand address generator: mode codes, field positions,
// descriptor offsets and operand sizes.
// assumes a 32-bit core with one clock; no other package is needed.
`default_nettype none

package oag_pkg;

    // ==========================================================
    // specifier codes and groups
    localparam logic [4:0] SPEC_MEMREL_FRAME = 5'h10;
    localparam logic [4:0] SPEC_MEMREL_STACK = 5'h11;
    localparam logic [4:0] SPEC_MEMREL_STAT = 5'h12;
    localparam logic [4:0] SPEC_RESERVED = 5'h13;
    localparam logic [4:0] SPEC_IMMEDIATE = 5'h14;
    localparam logic [4:0] SPEC_ABSOLUTE = 5'h15;
    localparam logic [4:0] SPEC_LINK_TABLE_MODE = 5'h16;
    localparam logic [4:0] SPEC_STACK_TOP_OPERAND = 5'h17;
    localparam logic [4:0] SPEC_SPACE_FRAME = 5'h18;
    localparam logic [4:0] SPEC_SPACE_STACK = 5'h19;
    localparam logic [4:0] SPEC_SPACE_STAT = 5'h1a;
    localparam logic [4:0] SPEC_SPACE_PROG = 5'h1b;
    localparam logic [1:0] GRP_REGISTER = 2'h0;
    localparam logic [1:0] GRP_REG_RELATIVE = 2'h1;
    localparam logic [2:0] GRP_SCALED = 3'h7;

    // ==========================================================
    // field positions
    localparam int IDX_MODE_LSB = 3;
    localparam int PSW_STACK_SEL_BIT = 9;
    localparam int LOW_STATE_BITS = 8;

    // ==========================================================
    // running unit descriptor: link table address word offset
    localparam logic [31:0] DESC_LINK_TABLE_OFS = 32'h0000_0004;
    localparam int LINK_ENTRY_SHIFT = 2;

    // ==========================================================
    // operand size codes and byte counts
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_DOUBLE = 2'h3;
    localparam logic [3:0] BYTES_1 = 4'h1;
    localparam logic [3:0] BYTES_2 = 4'h2;
    localparam logic [3:0] BYTES_4 = 4'h4;
    localparam logic [3:0] BYTES_8 = 4'h8;

    // ==========================================================
    // dedicated register selection codes
    localparam logic [2:0] AREG_STACK = 3'h0;
    localparam logic [2:0] AREG_STATIC = 3'h1;
    localparam logic [2:0] AREG_FRAME = 3'h2;
    localparam logic [2:0] AREG_UNIT_DESC = 3'h3;
    localparam logic [2:0] AREG_VECTOR_BASE = 3'h4;
    localparam logic [2:0] AREG_STATE_WORD = 3'h5;
    localparam logic [2:0] AREG_LOW_STATE_BYTE = 3'h6;

    // ==========================================================
    // reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

`default_nettype wire

// File: logic/oag_disp_decode.sv
// displacement field decoder: takes a field left-aligned in a 32-bit word,
// first stream byte in bits 31:24, and returns the signed value and length.
// assumes the instruction queue has already placed the field most
// significant byte first, as it appears in the stream.
`timescale 1ns/1ps
`default_nettype none

module oag_disp_decode
(
    // field in
    input wire logic [31:0] field_i,
    // decoded value and byte count
    output logic [31:0] value_o,
    output logic [2:0] length_o
);

    // ==========================================================
    // length from the top bits, remaining bits are two's complement
    always_comb
    begin
        if (!field_i[31])
        begin
            value_o = {{25{field_i[30]}}, field_i[30:24]};
            length_o = 3'h1;
        end
        else if (!field_i[30])
        begin
            value_o = {{18{field_i[29]}}, field_i[29:16]};
            length_o = 3'h2;
        end
        else
        begin
            value_o = {{2{field_i[29]}}, field_i[29:0]};
            length_o = 3'h4;
        end
    end

endmodule

`default_nettype wire

// File: logic/oag_operand_addr.sv
// operand addressing-mode decoder and effective address generator.
// assumes the decoder, register file and memory interface share clk_i;
// the register read port answers combinationally in the same cycle.
//
// Behaviour
// - codes 00000-00111 select general register directly
// - coprocessor flag redirects register mode to coprocessor bank
// - 01000-01111 address is displacement plus register
// - dedicated bases act like register relative
// - 10000 reads pointer at frame plus disp1
// - pointer-indirect fetches pointer before adding disp2
// - immediate from stream, illegal when written
// - absolute uses displacement as the address
// - external reads link table entry, adds disp2
// - stack top pops on read, pushes on write, unless indexed
// - scaled index adds register times 1/2/4/8
// - scaled index over immediate or index rejected
// - displacements accepted in 8, 16, 32 bits
// - implied immediate follows all addressing extensions
// - quick constant and condition from basic bytes
// - low state byte gives bottom eight state bits
// - 10001/10010 indirect via stack pointer, static base
// - 10100-10111 immediate, absolute, external, stack top
// - 11000-11011 frame, stack, static, program relative
// - 11100-11111 scale from code, index byte fields
`timescale 1ns/1ps
`default_nettype none

module oag_operand_addr
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // operand request from the decoder
    input wire logic start_i,
    input wire logic [4:0] spec_i,
    input wire logic [7:0] index_byte_i,
    input wire logic [31:0] disp1_field_i,
    input wire logic [31:0] disp2_field_i,
    input wire logic [31:0] imm_i,
    input wire logic is_write_i,
    input wire logic coproc_i,
    input wire logic [1:0] size_i,
    input wire logic float_i,
    // basic instruction fields
    input wire logic [3:0] quick_field_i,
    input wire logic [3:0] cond_field_i,
    // dedicated registers
    input wire logic [31:0] program_counter_i,
    input wire logic [31:0] interrupt_stack_pointer_i,
    input wire logic [31:0] user_stack_pointer_i,
    input wire logic [31:0] static_base_i,
    input wire logic [31:0] frame_pointer_i,
    input wire logic [31:0] running_unit_descriptor_i,
    input wire logic [31:0] vector_table_base_i,
    input wire logic [31:0] processor_state_word_i,
    input wire logic [2:0] areg_sel_i,
    // general register read port
    output logic [2:0] reg_sel_o,
    input wire logic [31:0] reg_data_i,
    // memory read port
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    // result
    output logic busy_o,
    output logic done_o,
    output logic illegal_o,
    output logic [1:0] kind_o,
    output logic [2:0] reg_num_o,
    output logic coproc_reg_o,
    output logic [31:0] ea_o,
    output logic [31:0] imm_o,
    output logic [3:0] size_bytes_o,
    output logic [3:0] ext_bytes_o,
    // stack pointer update
    output logic sp_update_o,
    output logic [31:0] sp_new_o,
    // dedicated and quick values
    output logic [31:0] areg_value_o,
    output logic [31:0] quick_const_o,
    output logic [3:0] cond_code_o
);

    // ==========================================================
    // helpers
    function automatic logic [3:0] size_to_bytes(input logic [1:0] sz, input logic fl);
        logic [3:0] b;
        b = oag_pkg::BYTES_4;
        if (fl)
            b = sz[0] ? oag_pkg::BYTES_8 : oag_pkg::BYTES_4;
        else if (sz == oag_pkg::SIZE_BYTE)
            b = oag_pkg::BYTES_1;
        else if (sz == oag_pkg::SIZE_WORD)
            b = oag_pkg::BYTES_2;
        return b;
    endfunction

    // modes carrying one and two displacement fields
    function automatic logic [1:0] disp_count(input logic [4:0] m);
        logic [1:0] n;
        n = 2'h0;
        if (m[4:3] == oag_pkg::GRP_REG_RELATIVE || m == oag_pkg::SPEC_ABSOLUTE
            || (m[4:3] == 2'h3 && m[4:2] != oag_pkg::GRP_SCALED))
            n = 2'h1;
        else if (m[4:2] == 3'h4 && m != oag_pkg::SPEC_RESERVED || m == oag_pkg::SPEC_LINK_TABLE_MODE)
            n = 2'h2;
        return n;
    endfunction

    // ==========================================================
    // displacement decoders
    logic [31:0] disp1;
    logic [31:0] disp2;
    logic [2:0] disp1_len;
    logic [2:0] disp2_len;

    oag_disp_decode u_disp1
    (
        .field_i(disp1_field_i),
        .value_o(disp1),
        .length_o(disp1_len)
    );

    oag_disp_decode u_disp2
    (
        .field_i(disp2_field_i),
        .value_o(disp2),
        .length_o(disp2_len)
    );

    // ==========================================================
    // request decode (combinational on the request cycle)
    logic scaled_req;
    logic [4:0] base_mode_req;
    logic bad_req;
    logic [1:0] ndisp;
    logic [3:0] ext_req;
    logic [31:0] cur_sp;

    // the stack pointer in use follows the state word select bit
    assign cur_sp = processor_state_word_i[oag_pkg::PSW_STACK_SEL_BIT]
        ? user_stack_pointer_i : interrupt_stack_pointer_i;
    assign scaled_req = (spec_i[4:2] == oag_pkg::GRP_SCALED);
    assign base_mode_req = scaled_req ? index_byte_i[7:oag_pkg::IDX_MODE_LSB] : spec_i;
    assign ndisp = disp_count(base_mode_req);

    // illegal: reserved code, written immediate, bad index base
    assign bad_req = (base_mode_req == oag_pkg::SPEC_RESERVED)
        || (base_mode_req == oag_pkg::SPEC_IMMEDIATE && (is_write_i || scaled_req))
        || (scaled_req && base_mode_req[4:2] == oag_pkg::GRP_SCALED);

    // extension bytes before any implied immediate: index byte then disps
    always_comb
    begin
        ext_req = {3'h0, scaled_req};
        if (ndisp != 2'h0)
            ext_req = ext_req + {1'b0, disp1_len};
        if (ndisp == 2'h2)
            ext_req = ext_req + {1'b0, disp2_len};
    end

    // ==========================================================
    // sequencer state, with its own kind and state types
    typedef enum logic [1:0] {KIND_REGISTER, KIND_IMMEDIATE, KIND_MEMORY} oag_kind_t;
    typedef enum logic [2:0] {ST_IDLE, ST_BASE, ST_LINK_RD, ST_PTR_RD, ST_INDEX, ST_DONE}
        oag_state_t;
    oag_state_t state, next_state;
    logic [4:0] mode, next_mode;
    logic scaled, next_scaled;
    logic [2:0] idx_reg, next_idx_reg;
    logic [1:0] scale, next_scale;
    logic [31:0] d1, next_d1;
    logic [31:0] d2, next_d2;
    logic wr, next_wr;
    logic cop, next_cop;
    logic [3:0] nbytes, next_nbytes;
    logic [31:0] ea, next_ea;
    logic [31:0] imm, next_imm;
    oag_kind_t kind, next_kind;
    logic ill, next_ill;
    logic [3:0] link_table_mode, next_ext;
    logic done, next_done;
    logic spu, next_spu;
    logic [31:0] spn, next_spn;
    logic mreq, next_mreq;
    logic [31:0] maddr, next_maddr;

    // register port follows the state: base register, then index register
    assign reg_sel_o = (state == ST_INDEX) ? idx_reg : mode[2:0];

    // next-state logic for the whole sequence
    always_comb
    begin
        next_state = state;
        next_mode = mode;
        next_scaled = scaled;
        next_idx_reg = idx_reg;
        next_scale = scale;
        next_d1 = d1;
        next_d2 = d2;
        next_wr = wr;
        next_cop = cop;
        next_nbytes = nbytes;
        next_ea = ea;
        next_imm = imm;
        next_kind = kind;
        next_ill = ill;
        next_ext = link_table_mode;
        next_done = 1'b0;
        next_spu = 1'b0;
        next_spn = spn;
        next_mreq = mreq;
        next_maddr = maddr;
        case (state)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    next_mode = base_mode_req;
                    next_scaled = scaled_req;
                    next_idx_reg = index_byte_i[2:0];
                    next_scale = spec_i[1:0];
                    next_d1 = disp1;
                    next_d2 = disp2;
                    next_wr = is_write_i;
                    next_cop = coproc_i;
                    next_nbytes = size_to_bytes(size_i, float_i);
                    next_ext = ext_req;
                    next_imm = imm_i;
                    next_ill = bad_req;
                    next_kind = KIND_MEMORY;
                    // illegal operands finish at once with no memory access
                    next_state = bad_req ? ST_DONE : ST_BASE;
                end
            end
            ST_BASE:
            begin
                next_state = next_scaled_or_done(scaled);
                if (mode[4:3] == oag_pkg::GRP_REGISTER)
                begin
                    // scaled over a register base uses its contents as address
                    next_kind = scaled ? KIND_MEMORY : KIND_REGISTER;
                    next_ea = reg_data_i;
                end
                else if (mode[4:3] == oag_pkg::GRP_REG_RELATIVE)
                    next_ea = d1 + reg_data_i;
                else
                begin
                    case (mode)
                        oag_pkg::SPEC_MEMREL_FRAME, oag_pkg::SPEC_MEMREL_STACK,
                        oag_pkg::SPEC_MEMREL_STAT:
                        begin
                            next_mreq = 1'b1;
                            next_maddr = d1 + ((mode == oag_pkg::SPEC_MEMREL_FRAME)
                                ? frame_pointer_i
                                : (mode == oag_pkg::SPEC_MEMREL_STACK)
                                ? cur_sp : static_base_i);
                            next_state = ST_PTR_RD;
                        end
                        oag_pkg::SPEC_IMMEDIATE:
                        begin
                            next_kind = KIND_IMMEDIATE;
                            next_state = ST_DONE;
                        end
                        oag_pkg::SPEC_ABSOLUTE:
                            next_ea = d1;
                        oag_pkg::SPEC_LINK_TABLE_MODE:
                        begin
                            // first fetch the link table address of the running unit
                            next_mreq = 1'b1;
                            next_maddr = running_unit_descriptor_i + oag_pkg::DESC_LINK_TABLE_OFS;
                            next_state = ST_LINK_RD;
                        end
                        oag_pkg::SPEC_STACK_TOP_OPERAND:
                        begin
                            // index over the stack top only addresses, no push or pop
                            next_ea = (wr && !scaled) ? cur_sp - {28'h0, nbytes} : cur_sp;
                            next_spu = !scaled;
                            next_spn = wr ? cur_sp - {28'h0, nbytes} : cur_sp + {28'h0, nbytes};
                        end
                        oag_pkg::SPEC_SPACE_FRAME:
                            next_ea = d1 + frame_pointer_i;
                        oag_pkg::SPEC_SPACE_STACK:
                            next_ea = d1 + cur_sp;
                        oag_pkg::SPEC_SPACE_STAT:
                            next_ea = d1 + static_base_i;
                        oag_pkg::SPEC_SPACE_PROG:
                            next_ea = d1 + program_counter_i;
                        default:
                        begin
                            next_ill = 1'b1;
                            next_state = ST_DONE;
                        end
                    endcase
                end
            end
            ST_LINK_RD:
            begin
                if (mem_ack_i)
                begin
                    // entry number disp1 scaled to a four-byte entry
                    next_maddr = mem_rdata_i + (d1 << oag_pkg::LINK_ENTRY_SHIFT);
                    next_state = ST_PTR_RD;
                end
            end
            ST_PTR_RD:
            begin
                if (mem_ack_i)
                begin
                    next_mreq = 1'b0;
                    next_ea = mem_rdata_i + d2;
                    next_state = next_scaled_or_done(scaled);
                end
            end
            ST_INDEX:
            begin
                next_ea = ea + (reg_data_i << scale);
                next_state = ST_DONE;
            end
            ST_DONE:
            begin
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // base done: go to indexing or finish
    function automatic oag_state_t next_scaled_or_done(input logic s);
        return s ? ST_INDEX : ST_DONE;
    endfunction

    // sequencer registers
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= ST_IDLE;
            mode <= 5'h00;
            scaled <= 1'b0;
            idx_reg <= 3'h0;
            scale <= 2'h0;
            d1 <= oag_pkg::RESET_WORD;
            d2 <= oag_pkg::RESET_WORD;
            wr <= 1'b0;
            cop <= 1'b0;
            nbytes <= oag_pkg::BYTES_4;
            ea <= oag_pkg::RESET_WORD;
            imm <= oag_pkg::RESET_WORD;
            kind <= KIND_REGISTER;
            ill <= 1'b0;
            link_table_mode <= 4'h0;
            done <= 1'b0;
            spu <= 1'b0;
            spn <= oag_pkg::RESET_WORD;
            mreq <= 1'b0;
            maddr <= oag_pkg::RESET_WORD;
        end
        else
        begin
            state <= next_state;
            mode <= next_mode;
            scaled <= next_scaled;
            idx_reg <= next_idx_reg;
            scale <= next_scale;
            d1 <= next_d1;
            d2 <= next_d2;
            wr <= next_wr;
            cop <= next_cop;
            nbytes <= next_nbytes;
            ea <= next_ea;
            imm <= next_imm;
            kind <= next_kind;
            ill <= next_ill;
            link_table_mode <= next_ext;
            done <= next_done;
            spu <= next_spu;
            spn <= next_spn;
            mreq <= next_mreq;
            maddr <= next_maddr;
        end
    end

    // ==========================================================
    // dedicated register view and quick fields
    logic [31:0] areg, next_areg;
    logic [31:0] quick, next_quick;
    logic [3:0] cond, next_cond;

    always_comb
    begin
        case (areg_sel_i)
            oag_pkg::AREG_STACK: next_areg = cur_sp;
            oag_pkg::AREG_STATIC: next_areg = static_base_i;
            oag_pkg::AREG_FRAME: next_areg = frame_pointer_i;
            oag_pkg::AREG_UNIT_DESC: next_areg = running_unit_descriptor_i;
            oag_pkg::AREG_VECTOR_BASE: next_areg = vector_table_base_i;
            oag_pkg::AREG_STATE_WORD: next_areg = processor_state_word_i;
            oag_pkg::AREG_LOW_STATE_BYTE:
                next_areg = {24'h0, processor_state_word_i[oag_pkg::LOW_STATE_BITS-1:0]};
            default: next_areg = oag_pkg::RESET_WORD;
        endcase
        next_quick = {{28{quick_field_i[3]}}, quick_field_i};
        next_cond = cond_field_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            areg <= oag_pkg::RESET_WORD;
            quick <= oag_pkg::RESET_WORD;
            cond <= 4'h0;
        end
        else
        begin
            areg <= next_areg;
            quick <= next_quick;
            cond <= next_cond;
        end
    end

    // ==========================================================
    // outputs
    assign busy_o = (state != ST_IDLE);
    assign done_o = done;
    assign illegal_o = ill;
    assign kind_o = kind;
    assign reg_num_o = mode[2:0];
    assign coproc_reg_o = cop && (kind == KIND_REGISTER);
    assign ea_o = ea;
    assign imm_o = imm;
    assign size_bytes_o = nbytes;
    assign ext_bytes_o = link_table_mode;
    assign sp_update_o = spu;
    assign sp_new_o = spn;
    assign mem_req_o = mreq;
    assign mem_addr_o = maddr;
    assign areg_value_o = areg;
    assign quick_const_o = quick;
    assign cond_code_o = cond;

endmodule

`default_nettype wire

// File: tb/oag_operand_addr_assertions.sv
// checker for the operand address generator, bound to its top ports.
// assumes one clock domain and the timing of the hand-over contract.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module oag_operand_addr_assertions
(
    // clock, reset and request
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [4:0] spec_i,
    input wire logic is_write_i,
    input wire logic [3:0] quick_field_i,
    input wire logic [3:0] cond_field_i,
    input wire logic mem_ack_i,
    // design outputs
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire logic [1:0] kind_o,
    input wire logic mem_req_o,
    input wire logic sp_update_o,
    input wire logic [31:0] quick_const_o,
    input wire logic [3:0] cond_code_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // a request only counts when the sequencer is idle
    wire logic taken = start_i && !busy_o;
    sequence s_ill_done;
        done_o && illegal_o;
    endsequence
    AST_REG_DONE: assert property (taken && spec_i[4:3] == 2'h0 |-> ##3 done_o && kind_o == 2'h0)
        else $error("register operand result late or wrong kind");
    AST_RESERVED: assert property (taken && spec_i == 5'h13 |-> (!mem_req_o)[*2] ##1 s_ill_done)
        else $error("reserved code not flagged or touched memory");
    AST_IMM_WRITE: assert property (taken && spec_i == 5'h14 && is_write_i |-> ##2 s_ill_done)
        else $error("written immediate not flagged");
    AST_REQ_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o)
        else $error("memory request dropped before answer");
    AST_DONE_PULSE: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    AST_SP_THEN_DONE: assert property (sp_update_o |=> done_o)
        else $error("stack update not followed by done");
    AST_QUICK: assert property ($past(resetn_i) |-> quick_const_o == {{28{$past(quick_field_i[3])}}, $past(quick_field_i)})
        else $error("quick constant wrong");
    AST_COND: assert property ($past(resetn_i) |-> cond_code_o == $past(cond_field_i))
        else $error("condition code wrong");
endmodule
bind oag_operand_addr oag_operand_addr_assertions u_chk (.*);
`default_nettype wire

// File: tb/oag_partner.sv
// register file and memory model on the far side of the generator.
// assumes the register port is combinational and memory acks are pulses.
`timescale 1ns/1ps
`default_nettype none
module oag_partner
(
    // clock, reset and pacing
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    // register and memory ports
    input wire logic [2:0] reg_sel_i,
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    output logic [31:0] reg_data_o,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    logic [1:0] wait_cnt;
    // register n holds n*100h+10h so each register is distinct
    assign reg_data_o = {21'h0, reg_sel_i, 8'h10};
    // data is only good in the ack cycle; inverted otherwise to expose early use
    assign mem_rdata_o = mem_ack_o ? mem_addr_i + 32'h1000 : ~(mem_addr_i + 32'h1000);
    // one-cycle ack after a short or long wait
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i || !mem_req_i || mem_ack_o)
        begin
            mem_ack_o <= 1'b0;
            wait_cnt <= 2'h0;
        end
        else if (wait_cnt == (slow_i ? 2'h3 : 2'h0))
            mem_ack_o <= 1'b1;
        else
            wait_cnt <= wait_cnt + 2'h1;
endmodule
`default_nettype wire

// File: tb/tb.sv
// testbench: one operand per call, expected address worked out here.
// assumes the partner model's register and memory contents.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i, resetn_i, start_i, is_write_i, coproc_i, float_i, mem_req_o, mem_ack_i, slow;
    logic busy_o, done_o, illegal_o, coproc_reg_o, sp_update_o;
    logic [4:0] spec_i;
    logic [7:0] index_byte_i;
    logic [1:0] size_i, kind_o;
    logic [2:0] areg_sel_i, reg_sel_o, reg_num_o;
    logic [3:0] quick_field_i, cond_field_i, size_bytes_o, ext_bytes_o, cond_code_o;
    logic [31:0] disp1_field_i, disp2_field_i, imm_i, program_counter_i, static_base_i;
    logic [31:0] interrupt_stack_pointer_i, user_stack_pointer_i, frame_pointer_i;
    logic [31:0] running_unit_descriptor_i, vector_table_base_i, processor_state_word_i;
    logic [31:0] reg_data_i, mem_addr_o, mem_rdata_i, ea_o, imm_o, sp_new_o;
    logic [31:0] areg_value_o, quick_const_o;
    int n_fail = 0, checks = 0;
    oag_operand_addr dut (.*);
    oag_partner u_far (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow), .reg_sel_i(reg_sel_o),
        .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .reg_data_o(reg_data_i),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    // ==========================================
    // clock and checks
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one operand request, waits for done under a bound
    task op(input logic [4:0] s, input logic [7:0] ix, input logic [31:0] d1, input logic wr,
            input logic [1:0] k, input logic [31:0] v, input logic il);
        int t;
        @(posedge clk_i);
        #2 spec_i = s; index_byte_i = ix; disp1_field_i = d1; is_write_i = wr; start_i = 1'b1;
        @(posedge clk_i);
        #2 start_i = 1'b0;
        t = 0;
        while (done_o !== 1'b1 && t < 40)
        begin
            @(posedge clk_i);
            #2 t++;
        end
        chk("done", 32'h1, {31'h0, done_o});
        chk("illegal", {31'h0, il}, {31'h0, illegal_o});
        if (!il)
        begin
            chk("kind", {30'h0, k}, {30'h0, kind_o});
            chk("value", v, k == 2'h0 ? {29'h0, reg_num_o} : k == 2'h1 ? imm_o : ea_o);
        end
        $display("test spec %h done", s);
    endtask
    // ==========================================
    // main sequence; r2=210h fp=4000h usp=6000h sb=7000h pc=8000h desc=9000h
    initial
    begin
        {start_i, is_write_i, float_i, slow} = '0;
        coproc_i = 1'b1; areg_sel_i = 3'h6;
        {spec_i, index_byte_i, disp1_field_i} = '0;
        size_i = 2'h3; quick_field_i = 4'h9; cond_field_i = 4'h6; imm_i = 32'ha5a5;
        disp2_field_i = 32'h0500_0000; frame_pointer_i = 32'h4000;
        interrupt_stack_pointer_i = 32'h5000; user_stack_pointer_i = 32'h6000;
        static_base_i = 32'h7000; program_counter_i = 32'h8000;
        running_unit_descriptor_i = 32'h9000; vector_table_base_i = 32'h300;
        processor_state_word_i = 32'h2a5;
        resetn_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #2 resetn_i = 1'b1;
        op(5'h03, 8'h0, 32'h0, 1'b0, 2'h0, 32'h3, 1'b0);
        chk("coproc", 32'h1, {31'h0, coproc_reg_o});
        op(5'h0a, 8'h0, 32'h0500_0000, 1'b0, 2'h2, 32'h215, 1'b0);
        op(5'h18, 8'h0, 32'h8100_0000, 1'b0, 2'h2, 32'h4100, 1'b0);
        op(5'h19, 8'h0, 32'h7f00_0000, 1'b0, 2'h2, 32'h5fff, 1'b0);
        op(5'h1a, 8'h0, 32'hc001_2345, 1'b0, 2'h2, 32'h19345, 1'b0);
        op(5'h1b, 8'h0, 32'h0500_0000, 1'b0, 2'h2, 32'h8005, 1'b0);
        op(5'h10, 8'h0, 32'h0500_0000, 1'b0, 2'h2, 32'h500a, 1'b0);
        op(5'h11, 8'h0, 32'h0500_0000, 1'b0, 2'h2, 32'h700a, 1'b0);
        slow = 1'b1;
        op(5'h12, 8'h0, 32'h0500_0000, 1'b0, 2'h2, 32'h800a, 1'b0);
        op(5'h16, 8'h0, 32'h0200_0000, 1'b0, 2'h2, 32'hb011, 1'b0);
        op(5'h14, 8'h0, 32'h0, 1'b0, 2'h1, 32'ha5a5, 1'b0);
        op(5'h14, 8'h0, 32'h0, 1'b1, 2'h2, 32'h0, 1'b1);
        op(5'h13, 8'h0, 32'h0, 1'b0, 2'h2, 32'h0, 1'b1);
        op(5'h15, 8'h0, 32'hc001_2345, 1'b0, 2'h2, 32'h12345, 1'b0);
        op(5'h17, 8'h0, 32'h0, 1'b0, 2'h2, 32'h6000, 1'b0);
        chk("sp_new", 32'h6004, sp_new_o);
        op(5'h1d, 8'h52, 32'h0500_0000, 1'b0, 2'h2, 32'h635, 1'b0);
        chk("ext", 32'h2, {28'h0, ext_bytes_o});
        chk("size", 32'h4, {28'h0, size_bytes_o});
        op(5'h1c, 8'ha0, 32'h0, 1'b0, 2'h2, 32'h0, 1'b1);
        chk("areg", 32'ha5, areg_value_o);
        close_out;
    end
    // watchdog well beyond the longest expected run
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        close_out;
    end
endmodule
`default_nettype wire
